// ---- rtl/standby_and_reset_control.sv ----
// Standby entry, release, warm-up and reset control with APB registers
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module standby_and_reset_control
	import standby_pkg::*;
#(
	parameter logic [TAP_W-1:0] WARM_SHORT_BITS = 5'd12,
	parameter logic [TAP_W-1:0] WARM_MID_BITS   = 5'd14,
	parameter logic [TAP_W-1:0] WARM_LONG_BITS  = 5'd16
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [DATA_W-1:0] pwdata,
	output var  logic              pready,
	output var  logic [DATA_W-1:0] prdata,
	output var  logic              pslverr,
	input  wire logic              key_input_line0,
	input  wire logic              reset_pin_n,
	output var  logic              osc_enable,
	output var  logic              cpu_run,
	output var  logic              cpu_reset,
	output var  logic              in_standby,
	output var  logic              warming_up,
	output var  logic [PC_W-1:0]   fetch_addr,
	output var  logic              status_flag,
	output var  logic [1:0]        data_bank_select,
	output var  logic              irq_master_enable,
	output var  logic [3:0]        irq_enable_mask,
	output var  logic [5:0]        irq_pending_latches
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		mode_e             mode;
		logic              level_mode;
		logic [1:0]        warm_sel;
		logic              pin_prev;
		logic [PC_W-1:0]   pc;
		logic              sflag;
		logic [1:0]        bank;
		logic              ime;
		logic [3:0]        mask;
		logic [5:0]        latches;
		logic [DATA_W-1:0] rdata;
		logic              err;
	} ctl_s;

	ctl_s state;
	ctl_s next_state;

	logic [1:0]       synced;
	logic             req_pin;
	logic             rst_pin_n;
	logic             setup;
	logic             access;
	logic             wr_ok;
	logic             bad_addr;
	logic             enter_cmd;
	logic [TAP_W-1:0] warm_bits;
	timer_if          tif ();

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Both pins idle high, so they start high to avoid a false release or reset
	pin_sync #(
		.WIDTH (2)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.pin_in   ({reset_pin_n, key_input_line0}),
		.pin_init (2'b11),
		.pin_out  (synced)
	);

	assign req_pin   = synced[0];
	assign rst_pin_n = synced[1];

	interval_timer u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.tif     (tif)
	);

	// ****************************************
	// Warm-up length select
	// ****************************************
	always_comb begin
		unique case (state.warm_sel)
			WARM_SHORT: warm_bits = WARM_SHORT_BITS;
			WARM_LONG:  warm_bits = WARM_LONG_BITS;
			default:    warm_bits = WARM_MID_BITS;
		endcase
	end

	// Warm-up ends when the timer reaches 2^bits basic clock periods
	assign tif.tap_index = warm_bits;

	// ****************************************
	// Bus decode
	// ****************************************
	assign setup  = psel && !penable;
	assign access = psel && penable;
	assign wr_ok  = access && pwrite && !state.err && (state.mode == ST_RUN);

	always_comb begin
		unique case (paddr)
			OFF_CMD, OFF_PIN, OFF_STATE, OFF_CPU, OFF_IRQ, OFF_TIMER, OFF_PC: bad_addr = 1'b0;
			default: bad_addr = 1'b1;
		endcase
	end

	assign enter_cmd = wr_ok && (paddr == OFF_CMD) && pwdata[CMD_ENTER_BIT];

	// ****************************************
	// Control process
	// ****************************************
	always_comb begin
		next_state          = state;
		next_state.pin_prev = req_pin;
		tif.clear           = 1'b0;

		// Read data are captured in the setup cycle so the access phase needs no wait
		if (setup) begin
			next_state.err   = bad_addr;
			next_state.rdata = '0;
			unique case (paddr)
				OFF_CMD: begin
					next_state.rdata[CMD_LEVEL_BIT]            = state.level_mode;
					next_state.rdata[CMD_WARM_LSB +: 2]        = state.warm_sel;
				end
				OFF_PIN: begin
					next_state.rdata[PIN_LEVEL_BIT]            = req_pin;
				end
				OFF_STATE: begin
					next_state.rdata[1:0]                      = state.mode;
				end
				OFF_CPU: begin
					next_state.rdata[CPU_IME_BIT]              = state.ime;
					next_state.rdata[CPU_BANK_LSB +: 2]        = state.bank;
					next_state.rdata[CPU_SF_BIT]               = state.sflag;
				end
				OFF_IRQ: begin
					next_state.rdata[IRQ_MASK_LSB +: 4]        = state.mask;
					next_state.rdata[IRQ_LATCH_LSB +: 6]       = state.latches;
				end
				OFF_TIMER: begin
					next_state.rdata[TIMER_W-1:0]              = tif.value;
				end
				OFF_PC: begin
					next_state.rdata[PC_W-1:0]                 = state.pc;
				end
				default: begin
					next_state.rdata = '0;
				end
			endcase
		end

		// Register writes only land while the core runs; standby freezes them
		if (wr_ok) begin
			unique case (paddr)
				OFF_CMD: begin
					next_state.level_mode = pwdata[CMD_LEVEL_BIT];
					next_state.warm_sel   = pwdata[CMD_WARM_LSB +: 2];
				end
				OFF_CPU: begin
					next_state.ime   = pwdata[CPU_IME_BIT];
					next_state.bank  = pwdata[CPU_BANK_LSB +: 2];
					next_state.sflag = pwdata[CPU_SF_BIT];
				end
				OFF_IRQ: begin
					next_state.mask    = pwdata[IRQ_MASK_LSB +: 4];
					next_state.latches = pwdata[IRQ_LATCH_LSB +: 6];
				end
				OFF_PC: begin
					next_state.pc = pwdata[PC_W-1:0];
				end
				default: begin
					next_state.err = state.err;
				end
			endcase
		end

		unique case (state.mode)
			ST_RUN: begin
				if (enter_cmd) begin
					tif.clear = 1'b1;
					if (pwdata[CMD_LEVEL_BIT] && req_pin) begin
						next_state.mode = ST_WARMUP;
					end else begin
						next_state.mode = ST_STANDBY;
					end
				end
			end
			ST_STANDBY: begin
				// Pc and cpu state are simply not written here, so they keep their values
				if (state.level_mode && req_pin) begin
					next_state.mode = ST_WARMUP;
				end else if (!state.level_mode && req_pin && !state.pin_prev) begin
					next_state.mode = ST_WARMUP;
				end
			end
			ST_WARMUP: begin
				if (tif.tap) begin
					tif.clear       = 1'b1;
					next_state.mode = ST_RUN;
				end
			end
			ST_RESET: begin
				tif.clear = 1'b1;
				if (rst_pin_n) begin
					next_state.mode = ST_RUN;
				end
			end
		endcase

		// Reset pin wins over everything, including a standby in progress
		if (!rst_pin_n) begin
			next_state.mode    = ST_RESET;
			next_state.pc      = RESTART_ADDR;
			next_state.sflag   = STATUS_FLAG_INIT;
			next_state.bank    = BANK_INIT;
			next_state.ime     = IME_INIT;
			next_state.mask    = MASK_INIT;
			next_state.latches = LATCH_INIT;
			tif.clear          = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state.mode       <= ST_RUN;
			state.level_mode <= 1'b0;
			state.warm_sel   <= WARM_INIT;
			state.pin_prev   <= 1'b1;
			state.pc         <= RESTART_ADDR;
			state.sflag      <= STATUS_FLAG_INIT;
			state.bank       <= BANK_INIT;
			state.ime        <= IME_INIT;
			state.mask       <= MASK_INIT;
			state.latches    <= LATCH_INIT;
			state.rdata      <= '0;
			state.err        <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Oscillator runs outside standby; warm-up restarts it before anything moves
	assign tif.count_en = (state.mode == ST_RUN) || (state.mode == ST_WARMUP);
	assign osc_enable   = (state.mode != ST_STANDBY);
	assign cpu_run      = (state.mode == ST_RUN);
	assign cpu_reset    = (state.mode == ST_RESET);
	assign in_standby   = (state.mode == ST_STANDBY);
	assign warming_up   = (state.mode == ST_WARMUP);
	assign fetch_addr   = state.pc;

	assign status_flag         = state.sflag;
	assign data_bank_select    = state.bank;
	assign irq_master_enable   = state.ime;
	assign irq_enable_mask     = state.mask;
	assign irq_pending_latches = state.latches;

	assign pready  = 1'b1;
	assign prdata  = state.rdata;
	assign pslverr = access && state.err;

endmodule // standby_and_reset_control
`default_nettype wire

// ---- rtl/standby_pkg.sv ----
// Constants, offsets and types shared by the standby and reset controller
// ****************************************
// Summary of operation
// ****************************************
// Summary of operation
// - Entering standby stops the oscillator and freezes all internal operation.
// - Entering standby clears the interval timer to zero.
// - Standby keeps memory, registers and latches exactly as before entry.
// - Program counter holds the address after the command write during standby.
// - Standby-request pin level reads as bit 0 of the pin status port.
// - Level-release mode leaves standby whenever the request pin is high.
// - Level mode command with pin high skips standby, starts warm-up at once.
// - Edge-release mode leaves standby only on a rising request-pin edge.
// - Edge-release mode enters standby even when the request pin is high.
// - Command 1101B starts level standby, 0101B edge standby, both 2^14 warm-up.
// - Release restarts the oscillator, then holds operation stopped during warm-up.
// - Software selects the warm-up length among three settings.
// - Warm-up is timed by the interval timer dividing the basic clock.
// - After warm-up, resume at the next instruction with timer counting from zero.
// - Low reset pin also ends standby; a normal reset follows at once.
// - Reset pin high ends reset; fetching starts at address 0000 hex.
// - Reset sets pc 0, status flag 1, bank, irq enables, latches, timer 0.
package standby_pkg;

	localparam int ADDR_W  = 12;
	localparam int DATA_W  = 32;
	localparam int TIMER_W = 18;
	localparam int PC_W    = 14;
	localparam int TAP_W   = 5;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [ADDR_W-1:0] OFF_CMD   = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_PIN   = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_STATE = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_CPU   = 12'h00c;
	localparam logic [ADDR_W-1:0] OFF_IRQ   = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_TIMER = 12'h014;
	localparam logic [ADDR_W-1:0] OFF_PC    = 12'h018;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CMD_LEVEL_BIT = 3;
	localparam int CMD_ENTER_BIT = 2;
	localparam int CMD_WARM_LSB  = 0;
	localparam int PIN_LEVEL_BIT = 0;
	localparam int CPU_IME_BIT   = 0;
	localparam int CPU_BANK_LSB  = 1;
	localparam int CPU_SF_BIT    = 3;
	localparam int IRQ_MASK_LSB  = 0;
	localparam int IRQ_LATCH_LSB = 4;

	// Warm-up select codes; 00 behaves as the middle setting
	localparam logic [1:0] WARM_SHORT = 2'b11;
	localparam logic [1:0] WARM_MID   = 2'b01;
	localparam logic [1:0] WARM_LONG  = 2'b10;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [PC_W-1:0]    RESTART_ADDR     = 14'h0000;
	localparam logic               STATUS_FLAG_INIT = 1'h1;
	localparam logic [1:0]         BANK_INIT        = 2'h0;
	localparam logic               IME_INIT         = 1'h0;
	localparam logic [3:0]         MASK_INIT        = 4'h0;
	localparam logic [5:0]         LATCH_INIT       = 6'h00;
	localparam logic [TIMER_W-1:0] TIMER_INIT       = 18'h00000;
	localparam logic [1:0]         WARM_INIT        = 2'h1;

	typedef enum logic [1:0] {
		ST_RUN     = 2'b00,
		ST_STANDBY = 2'b01,
		ST_WARMUP  = 2'b10,
		ST_RESET   = 2'b11
	} mode_e;

endpackage

// ---- rtl/timer_if.sv ----
// Carrier between the controller and its interval timer
`timescale 1ns/1ps
`default_nettype none
interface timer_if;
	import standby_pkg::*;
	logic                 clear;
	logic                 count_en;
	logic [TAP_W-1:0]     tap_index;
	logic                 tap;
	logic [TIMER_W-1:0]   value;

	modport ctl (output clear, output count_en, output tap_index, input tap, input value);
	modport tmr (input clear, input count_en, input tap_index, output tap, output value);
endinterface
`default_nettype wire

// ---- rtl/pin_sync.sv ----
// Two-stage synchroniser for the asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] pin_in,
	input  wire logic [WIDTH-1:0] pin_init,
	output var  logic [WIDTH-1:0] pin_out
);
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_s;

	sync_s state;
	sync_s next_state;

	always_comb begin
		next_state.stage1 = pin_in;
		next_state.stage2 = state.stage1;
	end

	// Reset value is a constant 1 on every bit; the pin_init vector is not used
	generate
		for (genvar i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					state.stage1[i] <= 1'b1;
					state.stage2[i] <= 1'b1;
				end else begin
					state.stage1[i] <= next_state.stage1[i];
					state.stage2[i] <= next_state.stage2[i];
				end
			end
		end
	endgenerate

	assign pin_out = state.stage2;
endmodule // pin_sync
`default_nettype wire

// ---- rtl/interval_timer.sv ----
// Free-running interval timer used as the clock divider for warm-up
`timescale 1ns/1ps
`default_nettype none
module interval_timer
	import standby_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	timer_if.tmr      tif
);
	typedef struct packed {
		logic [TIMER_W-1:0] value;
	} tmr_s;

	tmr_s               state;
	tmr_s               next_state;
	logic [TIMER_W-1:0] value_inc;

	// The tap looks one count ahead so that a warm-up lasts exactly 2^bits periods
	assign value_inc = state.value + 18'h00001;

	always_comb begin
		next_state = state;
		if (tif.clear) begin
			next_state.value = TIMER_INIT;
		end else if (tif.count_en) begin
			next_state.value = value_inc;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state.value <= TIMER_INIT;
		end else begin
			state <= next_state;
		end
	end

	assign tif.value = state.value;
	assign tif.tap   = value_inc[tif.tap_index];
endmodule // interval_timer
`default_nettype wire

// ---- tb/standby_props.sv ----
// Port-level checker for the standby and reset controller
`timescale 1ns/1ps
`default_nettype none
module standby_props
	import standby_pkg::*;
(
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            osc_enable,
	input  wire logic            cpu_run,
	input  wire logic            cpu_reset,
	input  wire logic            in_standby,
	input  wire logic            warming_up,
	input  wire logic [PC_W-1:0] fetch_addr,
	input  wire logic            status_flag,
	input  wire logic [1:0]      data_bank_select,
	input  wire logic            irq_master_enable,
	input  wire logic [3:0]      irq_enable_mask,
	input  wire logic [5:0]      irq_pending_latches
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic [13:0] cpu_regs = {status_flag, data_bank_select, irq_master_enable, irq_enable_mask,
		irq_pending_latches};

	chk_standby_stopped: assert property (in_standby |-> !osc_enable && !cpu_run)
		else $error("core or oscillator active in standby");
	chk_standby_pc_held: assert property (in_standby && $past(in_standby) |-> $stable(fetch_addr))
		else $error("program counter moved in standby");
	chk_standby_regs_held: assert property (in_standby && $past(in_standby) |-> $stable(cpu_regs))
		else $error("core registers moved in standby");
	chk_release_path: assert property ($fell(in_standby) |-> warming_up || cpu_reset)
		else $error("standby left without warm-up or reset");
	chk_warm_halted: assert property (warming_up |-> osc_enable && !cpu_run)
		else $error("core running or oscillator off in warm-up");
	// Shortest simulated warm-up is eight cycles
	chk_warm_min_len: assert property ($rose(warming_up) |-> (warming_up || cpu_reset) [*8])
		else $error("warm-up ended too early");
	chk_warm_resume: assert property ($fell(warming_up) && !cpu_reset |-> cpu_run && osc_enable)
		else $error("core not running after warm-up");
	chk_reset_hold: assert property (cpu_reset ##1 cpu_reset |-> !cpu_run && !in_standby && !warming_up)
		else $error("core active during reset");
	chk_reset_vector: assert property ($fell(cpu_reset) |-> fetch_addr == RESTART_ADDR && cpu_regs == 14'h2000)
		else $error("wrong state on reset release");
endmodule // standby_props

bind standby_and_reset_control standby_props i_standby_props (.pclk(pclk), .presetn(presetn),
	.osc_enable(osc_enable), .cpu_run(cpu_run), .cpu_reset(cpu_reset), .in_standby(in_standby),
	.warming_up(warming_up), .fetch_addr(fetch_addr), .status_flag(status_flag),
	.data_bank_select(data_bank_select), .irq_master_enable(irq_master_enable),
	.irq_enable_mask(irq_enable_mask), .irq_pending_latches(irq_pending_latches));
`default_nettype wire

// ---- tb/request_pin_model.sv ----
// Behavioural driver of the standby-request pin and the reset pin
`timescale 1ns/1ps
`default_nettype none
module request_pin_model #(
	parameter int RESET_MIN_CYCLES = 3
) (
	input  wire logic pclk,
	output var  logic key_input_line0,
	output var  logic reset_pin_n
);
	int low_cycles = 0;

	initial begin
		key_input_line0 = 1'b0;
		reset_pin_n     = 1'b1;
	end

	always @(posedge pclk) begin
		low_cycles <= reset_pin_n ? 0 : low_cycles + 1;
	end

	task automatic set_request(input logic level);
		@(posedge pclk);
		key_input_line0 <= level;
	endtask

	// A release asked for too soon is held back until the minimum low time is met
	task automatic set_reset(input logic level);
		@(posedge pclk);
		while (level && low_cycles < RESET_MIN_CYCLES) @(posedge pclk);
		reset_pin_n <= level;
	endtask
endmodule // request_pin_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the standby and reset controller
`timescale 1ns/1ps
`default_nettype none
module tb;
	import standby_pkg::*;
	localparam int WS = 3;
	localparam int WM = 4;
	localparam int WL = 5;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic key_input_line0, reset_pin_n, osc_enable, cpu_run, cpu_reset, in_standby, warming_up;
	logic status_flag, irq_master_enable;
	logic [PC_W-1:0] fetch_addr;
	logic [1:0] data_bank_select;
	logic [3:0] irq_enable_mask;
	logic [5:0] irq_pending_latches;
	int miscompares = 0;
	int checks_done = 0;

	standby_and_reset_control #(.WARM_SHORT_BITS(5'(WS)), .WARM_MID_BITS(5'(WM)), .WARM_LONG_BITS(5'(WL)))
		i_standby_and_reset_control (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
		.prdata, .pslverr, .key_input_line0, .reset_pin_n, .osc_enable, .cpu_run, .cpu_reset, .in_standby,
		.warming_up, .fetch_addr, .status_flag, .data_bank_select, .irq_master_enable, .irq_enable_mask,
		.irq_pending_latches);
	request_pin_model i_request_pin_model (.pclk, .key_input_line0, .reset_pin_n);

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) miscompares++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic warm_len(output logic [31:0] len);
		int n;
		n = 0;
		len = 0;
		while (warming_up !== 1'b1 && n < 20) begin
			@(negedge pclk);
			n++;
		end
		while (warming_up === 1'b1 && len < 100) begin
			@(negedge pclk);
			len++;
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset_values();
		logic [31:0] q;
		logic e;
		apb(1'b0, OFF_CPU, 0, q, e); check_val(q, 32'h8);
		apb(1'b0, OFF_IRQ, 0, q, e); check_val(q, 32'h0);
		apb(1'b0, OFF_PC, 0, q, e); check_val(q, 32'h0);
		apb(1'b0, 12'h020, 0, q, e); check_val({q[30:0], e}, 32'h1);
		$display("reset values done");
	endtask

	task automatic t_level();
		logic [31:0] q;
		logic e;
		i_request_pin_model.set_request(1'b1);
		repeat (4) @(posedge pclk);
		apb(1'b0, OFF_PIN, 0, q, e); check_val(q, 32'h1);
		i_request_pin_model.set_request(1'b0);
		repeat (4) @(posedge pclk);
		apb(1'b0, OFF_PIN, 0, q, e); check_val(q, 32'h0);
		apb(1'b1, OFF_CPU, 32'h5, q, e);
		apb(1'b1, OFF_PC, 32'h123, q, e);
		apb(1'b1, OFF_CMD, 32'hd, q, e);
		repeat (3) @(negedge pclk);
		check_val({osc_enable, cpu_run, in_standby}, 32'h1);
		apb(1'b0, OFF_TIMER, 0, q, e); check_val(q, 32'h0);
		apb(1'b0, OFF_STATE, 0, q, e); check_val(q, 32'h1);
		apb(1'b1, OFF_PC, 32'h3ff, q, e);
		i_request_pin_model.set_request(1'b1);
		warm_len(q); check_val(q, 32'(1 << WM));
		check_val(32'(cpu_run), 32'h1);
		apb(1'b0, OFF_PC, 0, q, e); check_val(q, 32'h123);
		apb(1'b0, OFF_CPU, 0, q, e); check_val(q, 32'h5);
		$display("level release done");
	endtask

	task automatic t_level_pin_high();
		logic [31:0] q;
		logic e;
		apb(1'b1, OFF_CMD, 32'hd, q, e);
		@(negedge pclk);
		check_val({in_standby, warming_up}, 32'h1);
		warm_len(q);
		$display("level skip done");
	endtask

	task automatic t_edge();
		logic [31:0] q;
		logic e;
		logic [1:0] code [4] = '{WARM_SHORT, WARM_LONG, WARM_MID, 2'b00};
		int exp [4] = '{1 << WS, 1 << WL, 1 << WM, 1 << WM};
		for (int i = 0; i < 4; i++) begin
			i_request_pin_model.set_request(i[0]);
			repeat (4) @(posedge pclk);
			apb(1'b1, OFF_CMD, {28'h0, 2'b01, code[i]}, q, e);
			repeat (12) @(negedge pclk);
			check_val(32'(in_standby), 32'h1);
			i_request_pin_model.set_request(1'b0);
			repeat (6) @(negedge pclk);
			check_val(32'(in_standby), 32'h1);
			i_request_pin_model.set_request(1'b1);
			warm_len(q); check_val(q, 32'(exp[i]));
		end
		$display("edge release done");
	endtask

	task automatic t_reset_in_standby();
		logic [31:0] q;
		logic e;
		int n;
		i_request_pin_model.set_request(1'b0);
		apb(1'b1, OFF_CPU, 32'h3, q, e);
		apb(1'b1, OFF_IRQ, 32'hf, q, e);
		apb(1'b1, OFF_PC, 32'h77, q, e);
		apb(1'b1, OFF_CMD, 32'h5, q, e);
		i_request_pin_model.set_reset(1'b0);
		repeat (5) @(negedge pclk);
		check_val({cpu_reset, in_standby, cpu_run}, 32'h4);
		i_request_pin_model.set_reset(1'b1);
		n = 0;
		while (cpu_run !== 1'b1 && n < 10) begin
			@(negedge pclk);
			n++;
		end
		check_val({status_flag, data_bank_select, irq_master_enable, irq_enable_mask, irq_pending_latches,
			fetch_addr}, {4'h0, 1'b1, 13'h0, RESTART_ADDR});
		$display("reset in standby done");
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		presetn = 1'b0;
		paddr = '0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		pwdata = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_values();
		t_level();
		t_level_pin_high();
		t_edge();
		t_reset_in_standby();
		give_verdict();
	end

	// Whole run is well under two thousand cycles
	initial begin
		#(50 * 20000);
		miscompares++;
		give_verdict();
	end
endmodule // tb
`default_nettype wire
